/* ial_consts.svh */
// Constants of the integer add, logic and shift datapath
`ifndef IAL_CONSTS_SVH
`define IAL_CONSTS_SVH
// ==========================================================
// Register byte offsets on the bus
`define IAL_A_OPA    8'h00
`define IAL_A_OPB    8'h04
`define IAL_A_CNT    8'h08
`define IAL_A_CTRL   8'h0c
`define IAL_A_FLAGS  8'h10
`define IAL_A_RESULT 8'h14
`define IAL_A_STATUS 8'h18
`define IAL_A_BTGT   8'h1c
`define IAL_A_IDX    8'h20
// ==========================================================
// Operation codes
`define IAL_OP_ADD  4'h0
`define IAL_OP_ADC  4'h1
`define IAL_OP_SUB  4'h2
`define IAL_OP_SWC  4'h3
`define IAL_OP_REV  4'h4
`define IAL_OP_AND  4'h5
`define IAL_OP_XOR  4'h6
`define IAL_OP_IOR  4'h7
`define IAL_OP_ANDN 4'h8
`define IAL_OP_ORC  4'h9
`define IAL_OP_ASHR 4'ha
`define IAL_OP_SHL  4'hb
`define IAL_OP_SHR  4'hc
`define IAL_OP_ROT  4'hd
`define IAL_OP_ROTX 4'he
// ==========================================================
// Control register fields
`define IAL_C_OP_HI  3
`define IAL_C_OP_LO  0
`define IAL_C_SF     4
`define IAL_C_USEIMM 5
`define IAL_C_IMM_HI 17
`define IAL_C_IMM_LO 6
`define IAL_C_SHN_HI 22
`define IAL_C_SHN_LO 18
`define IAL_C_SHI    23
`define IAL_C_C2V    24
`define IAL_C_C2     25
// Index register fields
`define IAL_I_PRI_HI 3
`define IAL_I_PRI_LO 0
`define IAL_I_DST_HI 7
`define IAL_I_DST_LO 4
`define IAL_I_DV     8
// Flag bit positions
`define IAL_F_N 3
`define IAL_F_Z 2
`define IAL_F_C 1
`define IAL_F_V 0
// Status register fields
`define IAL_S_IDX_HI 3
`define IAL_S_WBV    4
`define IAL_S_BRV    5
// ==========================================================
// Datapath constants
`define IAL_MSB        31
`define IAL_PC_IDX     4'hf
`define IAL_ALIGN_MASK 32'hffff_fffc
`define IAL_BR_MASK    32'hffff_fffe
`define IAL_SH_FULL    8'h20
`define IAL_SH_CLAMP   8'h21
`define IAL_WORD_BITS  6'h20
`define IAL_RST_WORD   32'h0000_0000
`define IAL_RST_FLAGS  4'h0
`endif

/* ial_pkg.sv */
// Types of the integer add, logic and shift datapath
package ial_pkg;
`include "ial_consts.svh"
   // ==========================================================
   // Operations
   typedef enum logic [3:0] {
      op_add                   = `IAL_OP_ADD,
      op_add_with_carry        = `IAL_OP_ADC,
      op_sub                   = `IAL_OP_SUB,
      op_subtract_with_carry   = `IAL_OP_SWC,
      op_reverse_subtract      = `IAL_OP_REV,
      op_and                   = `IAL_OP_AND,
      op_exclusive_or_op       = `IAL_OP_XOR,
      op_inclusive_or_op       = `IAL_OP_IOR,
      op_and_not_op            = `IAL_OP_ANDN,
      op_or_complement_op      = `IAL_OP_ORC,
      op_arith_shift_right     = `IAL_OP_ASHR,
      op_logical_shift_left    = `IAL_OP_SHL,
      op_logical_shift_right   = `IAL_OP_SHR,
      op_rotate_right          = `IAL_OP_ROT,
      op_rotate_right_extended = `IAL_OP_ROTX
   } ial_op_e;
   typedef logic [31:0] ial_word_t;
   // ==========================================================
   // Whole state of the datapath top
   typedef struct packed {
      ial_word_t opa;    // primary_operand_reg value
      ial_word_t opb;    // flexible_second_operand or shift_source_reg
      ial_word_t cnt;    // shift_count_reg value
      ial_word_t ctrl;   // last launched control word
      logic [8:0] idx;   // register indices
      logic [3:0] flags; // N Z C V
      ial_word_t result;
      ial_word_t btgt;
      logic [3:0] wb_idx;
      logic go;
      logic wb_v;
      logic br_v;
   } ial_state_s;
endpackage

/* ial_shift.sv */
// Barrel shifter and rotator with carry out
`timescale 1ns/1ps
`include "ial_consts.svh"
module ial_shift (
   input wire ial_pkg::ial_word_t value, // shift_source_reg value
   input wire logic [7:0] amount,        // shift length 0 to 255
   input wire ial_pkg::ial_op_e op,      // shift kind
   input wire logic carry_in,            // current carry flag
   output ial_pkg::ial_word_t result,    // shifted value
   output logic carry_out                // last bit shifted out
);
   logic [5:0] a6;
   logic [63:0] wl;
   logic [63:0] wr;
   logic [63:0] wa;
   logic [4:0] r5;
   ial_pkg::ial_word_t rot;
   logic zero;
   // ==========================================================
   // Clamp at 33: beyond that every shift gives the same answer
   assign a6 = (amount > `IAL_SH_CLAMP) ? 6'(`IAL_SH_CLAMP) : amount[5:0];
   assign zero = (amount == 8'h00);
   // Wide shifts keep the bit that falls out next to the result
   assign wl = {32'h0000_0000, value} << a6;
   assign wr = {value, 32'h0000_0000} >> a6;
   assign wa = $signed({value, 32'h0000_0000}) >>> a6;
   assign r5 = amount[4:0];
   assign rot = (value >> r5) | (value << (`IAL_WORD_BITS - {1'b0, r5}));
   // Select by kind; a zero length leaves the carry alone, except in rotate_right_extended
   always_comb begin
      result = value;
      carry_out = carry_in;
      case (op)
         ial_pkg::op_logical_shift_left: begin
            result = wl[31:0];
            carry_out = zero ? carry_in : wl[32]; // [RL20]
         end
         ial_pkg::op_logical_shift_right: begin
            result = wr[63:32];
            carry_out = zero ? carry_in : wr[31]; // [RL20]
         end
         ial_pkg::op_arith_shift_right: begin
            result = wa[63:32];
            carry_out = zero ? carry_in : wa[31]; // [RL20]
         end
         ial_pkg::op_rotate_right: begin
            result = rot;
            carry_out = zero ? carry_in : rot[`IAL_MSB]; // [RL20]
         end
         ial_pkg::op_rotate_right_extended: begin
            result = {carry_in, value[`IAL_MSB:1]}; // [RL17]
            carry_out = value[0];
         end
         default: begin
            result = value;
            carry_out = carry_in;
         end
      endcase
   end
endmodule

/* ial_top.sv */
// Integer add, logic and shift datapath with APB register access
//
// Behaviour
// RL1: add gives primary operand plus second operand or short immediate.
// RL2: add with carry sums primary, second operand and carry flag.
// RL3: subtract gives primary operand minus second operand or short immediate.
// RL4: subtract_with_carry subtracts second operand, one less when carry clear.
// RL5: reverse_subtract gives second operand minus primary operand.
// RL6: short immediate is any unsigned value 0 to 4095.
// RL7: with no destination given, result goes back to primary register.
// RL8: arithmetic with flag update sets N, Z, C and V.
// RL9: program counter as primary operand of add/subtract is word aligned.
// RL10: add writing program counter branches with bit zero forced low.
// RL11: and, exclusive_or_op and inclusive_or_op are bitwise on both operands.
// RL12: and_not_op ands primary with complement of second operand.
// RL13: or_complement_op ors primary with complement of second operand.
// RL14: logic with flag update sets N, Z, optional C, keeps V.
// RL15: register shift length uses low byte of shift_count_reg only.
// RL16: immediate length 1-32 for right shifts, 0-31 for left/rotate.
// RL17: rotate_right_extended moves the source right by exactly one.
// RL18: shifts write result register; shift source stays unchanged.
// RL19: shifts with flag update set N and Z from result.
// RL20: shifts load carry with last bit out, not for zero length.
// RL21: without flag update no flag changes at all.
`timescale 1ns/1ps
`include "ial_consts.svh"
module ial_top (
   input wire logic pclk,                 // Core clock, 200 MHz
   input wire logic presetn,              // Async reset, active low
   input wire logic psel,                 // APB select
   input wire logic penable,              // APB access phase
   input wire logic pwrite,               // APB write
   input wire logic [7:0] paddr,          // APB byte address
   input wire logic [31:0] pwdata,        // APB write data
   output logic [31:0] prdata,            // APB read data
   output logic pready,                   // APB ready, no wait states
   output logic pslverr,                  // APB error on unmapped address
   output logic wb_valid,                 // Result write back strobe
   output logic [3:0] wb_index,           // Write back register index
   output logic [31:0] wb_data,           // Write back value
   output logic branch_valid,             // Program counter write strobe
   output logic [31:0] branch_target,     // Branch address, bit zero low
   output logic [3:0] flags               // N Z C V
);
   ial_pkg::ial_state_s s;
   ial_pkg::ial_state_s n;
   ial_pkg::ial_op_e op;
   logic acc;
   logic wr;
   logic hit;
   logic sf;
   logic cf;
   logic pc_base;
   logic is_addsub;
   logic is_arith;
   logic is_logic;
   logic is_shift;
   logic right_imm;
   logic [4:0] shn;
   logic [7:0] amt;
   logic [3:0] dst;
   ial_pkg::ial_word_t imm;
   ial_pkg::ial_word_t a_val;
   ial_pkg::ial_word_t b_val;
   logic [33:0] ar;
   ial_pkg::ial_word_t lg;
   ial_pkg::ial_word_t sh;
   logic sh_c;
   ial_pkg::ial_word_t res;

   // ==========================================================
   // Helper functions
   // Add with carry in; returns {overflow, carry, sum}
   function automatic logic [33:0] add3(input ial_pkg::ial_word_t x, input ial_pkg::ial_word_t y,
                                        input logic ci);
      logic [32:0] t;
      logic ov;
      t = {1'b0, x} + {1'b0, y} + {32'h0000_0000, ci};
      ov = (x[`IAL_MSB] == y[`IAL_MSB]) && (t[`IAL_MSB] != x[`IAL_MSB]);
      return {ov, t};
   endfunction

   // Arithmetic group; subtraction is addition of the complement
   function automatic logic [33:0] arith(input ial_pkg::ial_op_e o, input ial_pkg::ial_word_t a,
                                         input ial_pkg::ial_word_t b, input logic c);
      case (o)
         ial_pkg::op_add: return add3(a, b, 1'b0); // [RL1]
         ial_pkg::op_add_with_carry: return add3(a, b, c); // [RL2]
         ial_pkg::op_sub: return add3(a, ~b, 1'b1); // [RL3]
         ial_pkg::op_subtract_with_carry: return add3(a, ~b, c); // [RL4]
         ial_pkg::op_reverse_subtract: return add3(b, ~a, 1'b1); // [RL5]
         default: return add3(a, b, 1'b0);
      endcase
   endfunction

   // Bitwise group
   function automatic ial_pkg::ial_word_t logic_op(input ial_pkg::ial_op_e o,
                                                   input ial_pkg::ial_word_t a,
                                                   input ial_pkg::ial_word_t b);
      case (o)
         ial_pkg::op_and: return a & b; // [RL11]
         ial_pkg::op_exclusive_or_op: return a ^ b; // [RL11]
         ial_pkg::op_inclusive_or_op: return a | b; // [RL11]
         ial_pkg::op_and_not_op: return a & ~b; // [RL12]
         ial_pkg::op_or_complement_op: return a | ~b; // [RL13]
         default: return a;
      endcase
   endfunction

   // ==========================================================
   // APB decode; always ready, so every access ends in one access cycle
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign hit = (paddr == `IAL_A_OPA) || (paddr == `IAL_A_OPB) || (paddr == `IAL_A_CNT) ||
                (paddr == `IAL_A_CTRL) || (paddr == `IAL_A_FLAGS) || (paddr == `IAL_A_RESULT) ||
                (paddr == `IAL_A_STATUS) || (paddr == `IAL_A_BTGT) || (paddr == `IAL_A_IDX);
   assign pready = 1'b1;
   assign pslverr = acc && !hit;
   // Read mux; unmapped addresses read as zero
   assign prdata = (paddr == `IAL_A_OPA) ? s.opa :
                   (paddr == `IAL_A_OPB) ? s.opb :
                   (paddr == `IAL_A_CNT) ? s.cnt :
                   (paddr == `IAL_A_CTRL) ? s.ctrl :
                   (paddr == `IAL_A_FLAGS) ? {28'h0000000, s.flags} :
                   (paddr == `IAL_A_RESULT) ? s.result :
                   (paddr == `IAL_A_STATUS) ? {26'h0, s.br_v, s.wb_v, s.wb_idx} :
                   (paddr == `IAL_A_BTGT) ? s.btgt :
                   (paddr == `IAL_A_IDX) ? {23'h0, s.idx} : `IAL_RST_WORD;

   // ==========================================================
   // Operand preparation from the launched control word
   assign op = ial_pkg::ial_op_e'(s.ctrl[`IAL_C_OP_HI:`IAL_C_OP_LO]);
   assign sf = s.ctrl[`IAL_C_SF];
   assign cf = s.flags[`IAL_F_C];
   assign is_addsub = (op == ial_pkg::op_add) || (op == ial_pkg::op_sub);
   assign is_arith = (op <= ial_pkg::op_reverse_subtract);
   assign is_shift = (op >= ial_pkg::op_arith_shift_right) && (op <= ial_pkg::op_rotate_right_extended);
   assign is_logic = !is_arith && !is_shift;
   assign pc_base = (s.idx[`IAL_I_PRI_HI:`IAL_I_PRI_LO] == `IAL_PC_IDX);
   // Only the add/sub forms take the 12-bit zero-extended immediate
   assign imm = 32'(s.ctrl[`IAL_C_IMM_HI:`IAL_C_IMM_LO]); // [RL6]
   assign a_val = (pc_base && is_addsub) ? (s.opa & `IAL_ALIGN_MASK) : s.opa; // [RL9]
   assign b_val = (is_addsub && s.ctrl[`IAL_C_USEIMM]) ? imm : s.opb; // [RL1] [RL3]

   // Shift length: immediate zero means 32 for the right shifts
   assign shn = s.ctrl[`IAL_C_SHN_HI:`IAL_C_SHN_LO];
   assign right_imm = (op == ial_pkg::op_arith_shift_right) || (op == ial_pkg::op_logical_shift_right);
   assign amt = !s.ctrl[`IAL_C_SHI] ? s.cnt[7:0] : // [RL15]
                (right_imm && (shn == 5'h00)) ? `IAL_SH_FULL : {3'h0, shn}; // [RL16]

   // ==========================================================
   // Datapath units
   assign ar = arith(op, a_val, b_val, cf);
   assign lg = logic_op(op, s.opa, s.opb);

   // Shifter reads the source copy only, never writes it back
   ial_shift u_shift (
      .value(s.opb),
      .amount(amt),
      .op(op),
      .carry_in(cf),
      .result(sh),
      .carry_out(sh_c)
   );

   assign res = is_arith ? ar[31:0] : is_shift ? sh : lg; // [RL18]
   assign dst = s.idx[`IAL_I_DV] ? s.idx[`IAL_I_DST_HI:`IAL_I_DST_LO] :
                s.idx[`IAL_I_PRI_HI:`IAL_I_PRI_LO]; // [RL7]

   // ==========================================================
   // Next state: bus writes, then the execute cycle after a control write
   always_comb begin
      n = s;
      n.go = 1'b0;
      n.wb_v = 1'b0;
      n.br_v = 1'b0;
      if (wr) begin
         case (paddr)
            `IAL_A_OPA: n.opa = pwdata;
            `IAL_A_OPB: n.opb = pwdata;
            `IAL_A_CNT: n.cnt = pwdata;
            `IAL_A_FLAGS: n.flags = pwdata[3:0];
            `IAL_A_IDX: n.idx = pwdata[8:0];
            `IAL_A_CTRL: begin
               n.ctrl = pwdata;
               n.go = 1'b1;
            end
            default: n.go = 1'b0;
         endcase
      end
      if (s.go) begin
         n.result = res;
         n.wb_v = 1'b1;
         n.wb_idx = dst;
         // Writing the program counter by add is a branch, bit zero dropped
         if ((dst == `IAL_PC_IDX) && (op == ial_pkg::op_add)) begin
            n.br_v = 1'b1; // [RL10]
            n.btgt = res & `IAL_BR_MASK; // [RL10]
         end
         // Flags move only when asked; otherwise all four hold
         if (sf) begin // [RL21]
            n.flags[`IAL_F_N] = res[`IAL_MSB]; // [RL8] [RL14] [RL19]
            n.flags[`IAL_F_Z] = (res == `IAL_RST_WORD); // [RL8] [RL14] [RL19]
            if (is_arith) begin
               n.flags[`IAL_F_C] = ar[32]; // [RL8]
               n.flags[`IAL_F_V] = ar[33]; // [RL8]
            end else if (is_shift) begin
               n.flags[`IAL_F_C] = sh_c; // [RL20]
            end else if (s.ctrl[`IAL_C_C2V]) begin
               n.flags[`IAL_F_C] = s.ctrl[`IAL_C_C2]; // [RL14]
            end
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Outputs straight from flops
   assign wb_valid = s.wb_v;
   assign wb_index = s.wb_idx;
   assign wb_data = s.result;
   assign branch_valid = s.br_v;
   assign branch_target = s.btgt;
   assign flags = s.flags;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Arithmetic group, each held against the plain formula of its rule
   add_result_a: assert property ( // [RL1]
      s.go && (op == ial_pkg::op_add) && !s.ctrl[`IAL_C_USEIMM] && !pc_base
      |=> s.wb_v && (s.result == $past(s.opa + s.opb)))
      else $error("add result wrong");

   adc_result_a: assert property ( // [RL2]
      s.go && (op == ial_pkg::op_add_with_carry)
      |=> s.result == $past(s.opa + s.opb + {31'h0, s.flags[`IAL_F_C]}))
      else $error("add with carry result wrong");

   sub_imm_a: assert property ( // [RL3]
      s.go && (op == ial_pkg::op_sub) && s.ctrl[`IAL_C_USEIMM] && !pc_base
      |=> s.result == $past(s.opa - imm))
      else $error("subtract immediate result wrong");

   swc_result_a: assert property ( // [RL4]
      s.go && (op == ial_pkg::op_subtract_with_carry)
      |=> s.result == $past(s.opa - s.opb - {31'h0, !s.flags[`IAL_F_C]}))
      else $error("subtract with carry result wrong");

   rev_sub_a: assert property ( // [RL5]
      s.go && (op == ial_pkg::op_reverse_subtract) |=> s.result == $past(s.opb - s.opa))
      else $error("reverse subtract result wrong");

   // Carry of a plain add comes from a 33-bit sum, not from the adder
   add_carry_a: assert property ( // [RL8]
      s.go && sf && (op == ial_pkg::op_add) && !s.ctrl[`IAL_C_USEIMM] && !pc_base
      |=> s.flags[`IAL_F_C] == ($past(33'(s.opa) + 33'(s.opb)) > 33'hffff_ffff))
      else $error("add carry flag wrong");

   // Destination and program counter
   dest_default_a: assert property ( // [RL7]
      s.go && !s.idx[`IAL_I_DV] |=> s.wb_v && (s.wb_idx == $past(s.idx[3:0])))
      else $error("default destination wrong");

   pc_align_a: assert property ( // [RL9]
      s.go && pc_base && is_addsub && s.ctrl[`IAL_C_USEIMM]
      |=> s.result == $past((op == ial_pkg::op_add) ? ({s.opa[31:2], 2'b00} + imm) :
                            ({s.opa[31:2], 2'b00} - imm)))
      else $error("program counter base not aligned");

   branch_tgt_a: assert property ( // [RL10]
      s.go && (op == ial_pkg::op_add) && (dst == `IAL_PC_IDX)
      |=> s.br_v && !s.btgt[0] && (s.btgt[31:1] == s.result[31:1]))
      else $error("branch target wrong");

   // Logic group
   xor_result_a: assert property ( // [RL11]
      s.go && (op == ial_pkg::op_exclusive_or_op) |=> s.result == $past(s.opa ^ s.opb))
      else $error("exclusive or result wrong");

   and_not_a: assert property ( // [RL12]
      s.go && (op == ial_pkg::op_and_not_op) |=> s.result == $past(s.opa & ~s.opb))
      else $error("and not result wrong");

   or_comp_a: assert property ( // [RL13]
      s.go && (op == ial_pkg::op_or_complement_op) |=> s.result == $past(s.opa | ~s.opb))
      else $error("or complement result wrong");

   logic_v_hold_a: assert property ( // [RL14]
      s.go && sf && is_logic |=> s.flags[`IAL_F_V] == $past(s.flags[`IAL_F_V]))
      else $error("logic op changed overflow");

   // Shift group
   shift_byte_a: assert property ( // [RL15]
      s.go && (op == ial_pkg::op_logical_shift_left) && !s.ctrl[`IAL_C_SHI]
      |=> s.result == $past(s.opb << s.cnt[7:0]))
      else $error("register shift length wrong");

   right_full_a: assert property ( // [RL16]
      s.go && s.ctrl[`IAL_C_SHI] && right_imm && (shn == 5'h00)
      |=> s.result == ((($past(op) == ial_pkg::op_arith_shift_right) && $past(s.opb[31])) ?
                       32'hffff_ffff : 32'h0))
      else $error("immediate shift of 32 wrong");

   rotx_one_a: assert property ( // [RL17]
      s.go && (op == ial_pkg::op_rotate_right_extended)
      |=> (s.result[30:0] == $past(s.opb[31:1])) && (s.result[31] == $past(cf)))
      else $error("extended rotate wrong");

   src_kept_a: assert property ( // [RL18]
      s.go && is_shift |=> $stable(s.opb))
      else $error("shift source modified");

   // Flags
   nz_flags_a: assert property ( // [RL19]
      s.go && sf |=> (s.flags[`IAL_F_Z] == (s.result == 32'h0)) && (s.flags[`IAL_F_N] == s.result[31]))
      else $error("negative or zero flag wrong");

   zero_len_a: assert property ( // [RL20]
      s.go && sf && is_shift && (op != ial_pkg::op_rotate_right_extended) && (amt == 8'h00)
      |=> s.flags[`IAL_F_C] == $past(cf))
      else $error("zero length shift changed carry");

   flags_hold_a: assert property ( // [RL21]
      s.go && !sf |=> $stable(s.flags) [*2])
      else $error("flags changed without update");

   // Main scenarios reached
   add_flags_c: cover property (s.go && sf && (op == ial_pkg::op_add) ##1 s.flags[`IAL_F_V]);
   branch_c: cover property (s.br_v);
   rotx_c: cover property (s.go && (op == ial_pkg::op_rotate_right_extended) && sf);
   unmapped_c: cover property (pslverr);
   pc_imm_c: cover property (s.go && pc_base && is_addsub && s.ctrl[`IAL_C_USEIMM]);
endmodule

/* ial_regfile_model.sv */
// Far-side model: register file that takes write backs and branches
`timescale 1ns/1ps
module ial_regfile_model (
   input wire logic pclk, // Core clock
   input wire logic presetn, // Async reset, active low
   input wire logic wb_valid, // Write back strobe
   input wire logic [3:0] wb_index, // Write back index
   input wire logic [31:0] wb_data, // Write back value
   input wire logic branch_valid, // Program counter strobe
   input wire logic [31:0] branch_target, // Branch address
   output logic [3:0] last_idx, // Index of the last write back
   output logic [7:0] wb_cnt, // Strobe cycles seen, one per operation
   output logic [31:0] br_pc, // Program counter after the last branch
   output logic [31:0] rd_val // Register content at the last index
);
   // ==========================================
   // Register array
   logic [31:0] regs [16];
   // Read back of the last written register
   assign rd_val = regs[last_idx];
   // Index and data linger after the strobe, so only the strobe cycle counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_idx <= 4'h0;
         wb_cnt <= 8'h00;
         br_pc <= 32'h0;
      end else begin
         if (wb_valid) begin
            regs[wb_index] <= wb_data;
            last_idx <= wb_index;
            wb_cnt <= wb_cnt + 8'h01;
         end
         if (branch_valid) begin
            br_pc <= branch_target;
         end
      end
   end
endmodule

/* test_integer_alu_shift_logic.sv */
// Self-checking bench for the add, logic and shift datapath
`timescale 1ns/1ps
`include "ial_consts.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_integer_alu_shift_logic;
   // ==========================================
   // Signals
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, se;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q, wb_data, branch_target;
   logic wb_valid, branch_valid;
   logic [3:0] wb_index, flags, last_idx;
   logic [7:0] wb_cnt, c0;
   logic [31:0] br_pc, rd_val;
   logic [31:0] lres [5] = '{32'hf000f000, 32'h0ff00ff0, 32'hfff0fff0, 32'h00f000f0, 32'hf0fff0ff};
   logic [3:0] lfl [5] = '{4'hb, 4'h3, 4'hb, 4'h3, 4'hb};
   int err_total = 0, comparisons = 0, cyc = 0;
   ial_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data), .branch_valid(branch_valid),
      .branch_target(branch_target), .flags(flags));
   ial_regfile_model u_rf (.pclk(pclk), .presetn(presetn), .wb_valid(wb_valid), .wb_index(wb_index),
      .wb_data(wb_data), .branch_valid(branch_valid), .branch_target(branch_target),
      .last_idx(last_idx), .wb_cnt(wb_cnt), .br_pc(br_pc), .rd_val(rd_val));
   // Clock, 5 ns period
   always #2.5 pclk = ~pclk;
   // Ceiling is several times the length of the whole sequence
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         report_and_stop();
      end
   end
   // ==========================================
   // Bus tasks: request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] ctl(input logic [3:0] op, input int s, im, v,
      input int n, shi);
      ctl = 32'(op) | (32'(s) << `IAL_C_SF) | (32'(im) << `IAL_C_USEIMM) | (32'(v) << `IAL_C_IMM_LO)
         | (32'(n) << `IAL_C_SHN_LO) | (32'(shi) << `IAL_C_SHI);
   endfunction
   // Loads operands and flags, launches, then reads result and flags back
   task automatic run(input logic [31:0] c, a, b, n, input logic [8:0] ix, input logic [3:0] fi,
      input logic [31:0] er, input logic [3:0] ef);
      apb(1'b1, `IAL_A_OPA, a, q);
      apb(1'b1, `IAL_A_OPB, b, q);
      apb(1'b1, `IAL_A_CNT, n, q);
      apb(1'b1, `IAL_A_IDX, {23'h0, ix}, q);
      apb(1'b1, `IAL_A_FLAGS, {28'h0, fi}, q);
      c0 = wb_cnt;
      apb(1'b1, `IAL_A_CTRL, c, q);
      apb(1'b0, `IAL_A_RESULT, 32'h0, q);
      `CHK("result", er, q)
      apb(1'b0, `IAL_A_FLAGS, 32'h0, q);
      `CHK("flags", {28'h0, ef}, q)
      `CHK("flag pins", ef, flags)
      `CHK("mapped error", 1'b0, se)
      `CHK("register file", er, rd_val)
      `CHK("write back pulses", c0 + 8'h01, wb_cnt)
   endtask
   task automatic report_and_stop();
      $display("Counts: err_total=%0d comparisons=%0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `IAL_A_FLAGS, 32'h0, q);
      `CHK("flags reset", 32'h0, q)
      apb(1'b0, 8'h24, 32'h0, q);
      `CHK("unmapped data", 32'h0, q)
      `CHK("unmapped error", 1'b1, se)
      run(ctl(4'h0, 1, 0, 0, 0, 0), 32'hffffffff, 32'h1, 0, 9'h003, 4'h0, 32'h0, 4'h6);
      `CHK("dest absent", 4'h3, last_idx)
      run(ctl(4'h0, 0, 1, 12'hfff, 0, 0), 32'h1, 32'h0, 0, 9'h195, 4'h0, 32'h1000, 4'h0);
      `CHK("dest given", 4'h9, last_idx)
      run(ctl(4'h1, 0, 0, 0, 0, 0), 32'h5, 32'h3, 0, 9'h003, 4'h2, 32'h9, 4'h2);
      run(ctl(4'h2, 1, 0, 0, 0, 0), 32'h80000000, 32'h1, 0, 9'h003, 4'h0, 32'h7fffffff, 4'h3);
      run(ctl(4'h2, 0, 1, 12'h010, 0, 0), 32'h20, 32'h0, 0, 9'h003, 4'h0, 32'h10, 4'h0);
      run(ctl(4'h3, 0, 0, 0, 0, 0), 32'ha, 32'h3, 0, 9'h003, 4'h0, 32'h6, 4'h0);
      run(ctl(4'h4, 1, 0, 0, 0, 0), 32'ha, 32'h3, 0, 9'h003, 4'h0, 32'hfffffff9, 4'h8);
      for (int i = 0; i < 5; i++) begin
         run(ctl(4'(5 + i), 1, 0, 0, 0, 0), 32'hf0f0f0f0, 32'hff00ff00, 0, 9'h003, 4'h3, lres[i], lfl[i]);
      end
      run(ctl(4'h5, 1, 0, 0, 0, 0) | (32'h1 << `IAL_C_C2V), 32'hf0f0f0f0, 32'hff00ff00, 0, 9'h003, 4'h3,
         32'hf000f000, 4'h9);
      run(ctl(4'hb, 1, 0, 0, 0, 0), 0, 32'h10000001, 32'h104, 9'h003, 4'h0, 32'h10, 4'h2);
      run(ctl(4'hb, 1, 0, 0, 0, 0), 0, 32'h10000001, 32'h120, 9'h003, 4'h0, 32'h0, 4'h6);
      run(ctl(4'hc, 1, 0, 0, 0, 1), 0, 32'h80000000, 0, 9'h003, 4'h0, 32'h0, 4'h6);
      run(ctl(4'ha, 1, 0, 0, 0, 1), 0, 32'h80000000, 0, 9'h003, 4'h0, 32'hffffffff, 4'ha);
      run(ctl(4'hd, 1, 0, 0, 8, 1), 0, 32'h12345678, 0, 9'h003, 4'h0, 32'h78123456, 4'h0);
      apb(1'b0, `IAL_A_OPB, 32'h0, q);
      `CHK("shift source", 32'h12345678, q)
      run(ctl(4'hb, 1, 0, 0, 0, 1), 0, 32'h80000000, 0, 9'h003, 4'h2, 32'h80000000, 4'ha);
      run(ctl(4'he, 1, 0, 0, 0, 0), 0, 32'h3, 0, 9'h003, 4'h2, 32'h80000001, 4'ha);
      run(ctl(4'h0, 0, 0, 0, 0, 0), 32'h1, 32'h1, 0, 9'h003, 4'hf, 32'h2, 4'hf);
      run(ctl(4'hd, 0, 0, 0, 4, 1), 0, 32'hf, 0, 9'h003, 4'h5, 32'hf0000000, 4'h5);
      run(ctl(4'h0, 0, 0, 0, 0, 0), 32'h1001, 32'h3, 0, 9'h1ff, 4'h0, 32'h1003, 4'h0);
      `CHK("branch target", 32'h1002, br_pc)
      run(ctl(4'h2, 0, 1, 12'h004, 0, 0), 32'h1003, 32'h0, 0, 9'h00f, 4'h0, 32'hffc, 4'h0);
      `CHK("no branch", 32'h1002, br_pc)
      apb(1'b0, `IAL_A_BTGT, 32'h0, q);
      `CHK("branch register", 32'h1002, q)
      apb(1'b0, `IAL_A_STATUS, 32'h0, q);
      `CHK("status", 32'h0f, q)
      report_and_stop();
   end
endmodule
